// >>> logic/drive_state_status_word.sv
`timescale 1ns/1ps
module drive_state_status_word
  import drive_state_pkg::*;
#(
  parameter int ADDR_W      = 8,
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              supply_present,
  input  wire logic              fault_in,
  input  wire logic              motor_stopped,
  input  wire logic              warning_in,
  input  wire logic              net_control,
  input  wire logic              ref_reached,
  input  wire logic              ref_limit,
  input  wire logic              stop_key,
  input  wire logic              dir_reverse,
  output logic [15:0]            drive_state_word,
  output logic                   contactor_close,
  output logic                   motor_power,
  output logic                   halt_active,
  output logic                   no_supply_indication
);
  localparam int NPIN = 9;

  logic [NPIN-1:0] pins_s;
  logic            sup_s, flt_s, stopped_s, warn_s, net_s, refok_s, lim_s, key_s, dir_s;

  pin_sync #(.WIDTH(NPIN)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     ({dir_reverse, stop_key, ref_limit, ref_reached, net_control,
                warning_in, motor_stopped, fault_in, supply_present}),
    .pin_s   (pins_s)
  );
  assign {dir_s, key_s, lim_s, refok_s, net_s, warn_s, stopped_s, flt_s, sup_s} = pins_s;

  // register file
  logic [15:0]  ctrl_reg;
  logic [31:0]  cfg_reg;
  logic [1:0]   cause_reg;
  logic [1:0]   cause_next;
  logic [15:0]  status_reg;
  logic [15:0]  status_next;
  drive_state_t state_reg;
  drive_state_t state_next;
  logic         qs_fault_reg;
  logic         qs_fault_next;
  logic         fr_prev_reg;

  // write and read channels
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  wire wa_hi0   = (aw_addr_reg[ADDR_W-1:4] == '0);
  wire wr_ctrl  = do_write && wa_hi0 && aw_addr_reg[3:0] == ADDR_CTRL;
  wire wr_cfg   = do_write && wa_hi0 && aw_addr_reg[3:0] == ADDR_CFG;
  wire wr_bad   = do_write && !wr_ctrl && !wr_cfg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[b*8 +: 8] = data[b*8 +: 8];
      end
    end
  endfunction

  wire [31:0] ctrl_merged = merge({16'h0000, ctrl_reg}, w_data_reg, w_strb_reg);
  wire [31:0] cfg_merged  = merge(cfg_reg, w_data_reg, w_strb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      ctrl_reg   <= CTRL_RESET;
      cfg_reg    <= CFG_RESET;
    end else begin
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_reg <= ctrl_merged[15:0];
      end
      if (wr_cfg) begin
        cfg_reg <= cfg_merged;
      end
    end
  end

  // read channel
  wire ra_hi0 = (s_axi_araddr[ADDR_W-1:4] == '0);
  wire [3:0] ra = s_axi_araddr[3:0];
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_ok   = ra_hi0;
    rd_word = 32'h0000_0000;
    if (ra_hi0 && ra == ADDR_STATUS) begin
      rd_word = {16'h0000, status_reg};
    end else if (ra_hi0 && ra == ADDR_CTRL) begin
      rd_word = {16'h0000, ctrl_reg};
    end else if (ra_hi0 && ra == ADDR_CFG) begin
      rd_word = cfg_reg;
    end else if (ra_hi0 && ra == ADDR_CAUSE) begin
      rd_word = {30'h0000_0000, cause_reg};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      rdata_reg  <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // control word decode
  supply_mode_t mode;
  assign mode = supply_mode_t'(cfg_reg[CFG_MODE_LSB +: 2]);
  wire cmd_dis_volt = !ctrl_reg[CW_EV];
  wire cmd_qstop    = ctrl_reg[CW_EV] && !ctrl_reg[CW_QS];
  wire cmd_shutdown = ctrl_reg[CW_QS] && ctrl_reg[CW_EV] && !ctrl_reg[CW_SON];
  wire cmd_son      = ctrl_reg[CW_QS] && ctrl_reg[CW_EV] && ctrl_reg[CW_SON];
  wire cmd_enable   = cmd_son && ctrl_reg[CW_EO];
  wire fr_rise      = ctrl_reg[CW_FR] && !fr_prev_reg;
  wire tmo_expired;
  wire fault_event  = flt_s || tmo_expired;

  mains_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .run      (state_reg == ST_SON && !sup_s),
    .limit_ms (cfg_reg[CFG_TMO_LSB +: 16]),
    .expired  (tmo_expired)
  );

  always_comb begin
    state_next    = state_reg;
    qs_fault_next = qs_fault_reg;
    cause_next    = cause_reg;
    case (state_reg)
      ST_NOT_READY: begin
        state_next = ST_SOD;
      end
      ST_SOD: begin
        if (cmd_shutdown) begin
          state_next = ST_READY;
        end
      end
      ST_READY: begin
        // enable alone is accepted; it steps through switched on first
        if (cmd_dis_volt || cmd_qstop) begin
          state_next = ST_SOD;
        end else if (cmd_son) begin
          state_next = ST_SON;
        end
      end
      ST_SON: begin
        if (cmd_dis_volt || cmd_qstop) begin
          state_next = ST_SOD;
        end else if (cmd_shutdown) begin
          state_next = ST_READY;
        end else if (cmd_enable) begin
          state_next = ST_OPEN;
        end
      end
      ST_OPEN: begin
        // halt only gates motor power, never the state
        if (cmd_dis_volt) begin
          state_next = ST_SOD;
        end else if (cmd_qstop) begin
          state_next = ST_QSTOP;
        end else if (cmd_shutdown) begin
          state_next = ST_READY;
        end else if (!ctrl_reg[CW_EO]) begin
          state_next = ST_SON;
        end
      end
      ST_QSTOP: begin
        if (cmd_dis_volt || stopped_s) begin
          state_next = ST_SOD;
        end
      end
      ST_FREACT: begin
        state_next = ST_FAULT;
      end
      default: begin
        if (fr_rise && !fault_event) begin
          state_next = ST_SOD;
          cause_next = 2'h0;
        end
      end
    endcase
    if (state_reg != ST_FAULT && state_reg != ST_FREACT) begin
      if (tmo_expired && state_reg == ST_SON) begin
        state_next = ST_FAULT;
        cause_next[CAUSE_CONTACTOR] = 1'b1;
        qs_fault_next = 1'b0;
      end else if (flt_s) begin
        state_next = ST_FREACT;
        cause_next[CAUSE_EXTERNAL] = 1'b1;
        qs_fault_next = (state_reg == ST_QSTOP);
      end
    end
  end

  // status computed from the next state so word and state switch together
  wire n_sod = state_next == ST_SOD;
  wire n_rdy = state_next == ST_READY;
  wire n_son = state_next == ST_SON;
  wire n_opn = state_next == ST_OPEN;
  wire n_qs  = state_next == ST_QSTOP;
  wire n_fr  = state_next == ST_FREACT;
  wire n_flt = state_next == ST_FAULT;
  always_comb begin
    status_next              = 16'h0000;
    status_next[SW_RDY]      = n_rdy || n_son || n_opn || n_qs || n_fr;
    status_next[SW_SON]      = n_son || n_opn || n_qs || n_fr;
    status_next[SW_OPEN]     = n_opn || n_qs || n_fr;
    status_next[SW_FLT]      = n_fr || n_flt;
    status_next[SW_VEN]      = sup_s || n_son || n_opn || n_qs;
    status_next[SW_QS]       = n_rdy || n_son || n_opn || ((n_fr || n_flt) && !qs_fault_next);
    status_next[SW_SOD]      = n_sod;
    status_next[SW_WARN]     = warn_s;
    status_next[SW_REMOTE]   = net_s;
    status_next[SW_REFOK]    = refok_s;
    status_next[SW_LIMIT]    = lim_s;
    status_next[SW_STOPKEY]  = key_s;
    status_next[SW_DIR]      = dir_s;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg    <= ST_NOT_READY;
      status_reg   <= 16'h0000;
      qs_fault_reg <= 1'b0;
      cause_reg    <= 2'h0;
      fr_prev_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      status_reg   <= status_next;
      qs_fault_reg <= qs_fault_next;
      cause_reg    <= cause_next;
      fr_prev_reg  <= ctrl_reg[CW_FR];
    end
  end

  wire st_live = state_reg == ST_SON || state_reg == ST_OPEN || state_reg == ST_QSTOP;
  assign drive_state_word     = status_reg;
  assign contactor_close      = (mode == SUPPLY_CONTACTOR) && st_live;
  assign motor_power          = (state_reg == ST_OPEN && !ctrl_reg[CW_HALT]) ||
                                state_reg == ST_QSTOP;
  assign halt_active          = state_reg == ST_OPEN && ctrl_reg[CW_HALT];
  assign no_supply_indication = state_reg == ST_READY && !sup_s;

  wire [15:0] masked = status_reg & STATE_MASK;

  sequence s_enable_ready;
    state_reg == ST_READY && cmd_enable && !fault_event;
  endsequence
  sequence s_enable_kept;
    s_enable_ready ##1 (cmd_enable && !fault_event && !flt_s);
  endsequence

  AST_NOT_READY: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_NOT_READY |-> (status_reg & 16'h004F) == 16'h0000)
    else $error("not ready state shows state bits");
  AST_SOD_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_SOD |-> masked == MASKED_SOD && status_reg[SW_SOD])
    else $error("switch on disabled word wrong");
  AST_ON_MASKS: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_SON |-> masked == MASKED_SON) and
    (state_reg == ST_OPEN |-> masked == MASKED_OPN))
    else $error("switched on or enabled word wrong");
  AST_READY_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_READY && $past(sup_s) |-> status_reg[6:0] == LOW_RDY_SUP)
    else $error("ready with supply word wrong");
  AST_READY_NOSUP: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_READY && !$past(sup_s) |-> status_reg[6:0] == LOW_RDY_NOSUP)
    else $error("ready without supply word wrong");
  AST_QSTOP: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_QSTOP |-> masked == MASKED_QS && status_reg[SW_VEN])
    else $error("quick stop word wrong");
  AST_QS_BIT5: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state_reg == ST_QSTOP) |-> !status_reg[SW_QS] && $past(status_reg[SW_QS]))
    else $error("quick stop bit not cleared on entry");
  AST_FREACT: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_FREACT |-> status_reg[3:0] == 4'hF && !status_reg[SW_SOD]
    ##1 state_reg == ST_FAULT)
    else $error("fault reaction word wrong");
  AST_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_FAULT |-> masked == (qs_fault_reg ? MASKED_FQS : MASKED_FLT))
    else $error("fault word wrong");
  AST_PASS_THROUGH: assert property (@(posedge aclk) disable iff (!aresetn)
    s_enable_kept |=> state_reg == ST_OPEN ##0 $past(state_reg) == ST_SON)
    else $error("enable from ready did not reach enabled via switched on");
  AST_REFS: assert property (@(posedge aclk) disable iff (!aresetn)
    !status_reg[8] && status_reg[SW_REFOK] == $past(refok_s) &&
    status_reg[SW_LIMIT] == $past(lim_s) && status_reg[SW_REMOTE] == $past(net_s))
    else $error("reference or remote bits wrong");
  AST_TIMEOUT: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_SON && tmo_expired |=> state_reg == ST_FAULT && cause_reg[CAUSE_CONTACTOR])
    else $error("mains timeout did not fault");
  AST_CONTACTOR: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_READY && mode == SUPPLY_CONTACTOR && cmd_son && !fault_event
    |-> !contactor_close ##1 contactor_close)
    else $error("contactor not closed on switch on");
  AST_FR_EDGE: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_FAULT && !fr_rise |=> state_reg == ST_FAULT)
    else $error("fault left without reset edge");
  AST_HALT: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_OPEN && cmd_enable && ctrl_reg[CW_HALT] && !flt_s
    |-> !motor_power ##1 state_reg == ST_OPEN)
    else $error("halt left operation enabled");
  AST_COHERENT: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(state_reg) |-> status_reg[SW_SOD] == (state_reg == ST_SOD) &&
    status_reg[SW_FLT] == (state_reg == ST_FAULT || state_reg == ST_FREACT))
    else $error("status word lags the state");
endmodule

// >>> logic/drive_state_pkg.sv
// Overview of operation
// - bit4 supply, bit5 quick stop, bit6 disabled
// - bit8 zero, bits 9-11 remote, reached, limits
// - not ready clears bits 6,3,2,1,0
// - switch on disabled masks to 0x0040
// - ready 0x21, switched on 0x23, enabled 0x27
// - quick stop active masks to 0x0007
// - fault reaction sets bits 3..0, clears 6
// - fault masks 0x0008 after quick stop, else 0x0028
// - enable from ready passes through switched on
// - ready shows 0x21 without supply, 0x31 with
// - supply missing after timeout gives contactor fault
// - contactor open until switch on received
// - fault reset acts on rising edge only
// - halt stops motor, stays operation enabled
package drive_state_pkg;
  localparam int CLK_PERIOD_NS   = 50;
  localparam int MS_NS           = 1000000;
  localparam int TICK_CYCLES_DEF = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CTRL   = 4'h4;
  localparam logic [3:0] ADDR_CFG    = 4'h8;
  localparam logic [3:0] ADDR_CAUSE  = 4'hC;

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [31:0] CFG_RESET  = 32'h03E8_0000;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_TMO_LSB  = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int SW_RDY     = 0;
  localparam int SW_SON     = 1;
  localparam int SW_OPEN    = 2;
  localparam int SW_FLT     = 3;
  localparam int SW_VEN     = 4;
  localparam int SW_QS      = 5;
  localparam int SW_SOD     = 6;
  localparam int SW_WARN    = 7;
  localparam int SW_REMOTE  = 9;
  localparam int SW_REFOK   = 10;
  localparam int SW_LIMIT   = 11;
  localparam int SW_STOPKEY = 14;
  localparam int SW_DIR     = 15;

  localparam int CW_SON  = 0;
  localparam int CW_EV   = 1;
  localparam int CW_QS   = 2;
  localparam int CW_EO   = 3;
  localparam int CW_FR   = 7;
  localparam int CW_HALT = 8;

  localparam int CAUSE_CONTACTOR = 0;
  localparam int CAUSE_EXTERNAL  = 1;

  localparam logic [15:0] STATE_MASK = 16'h006F;
  localparam logic [15:0] MASKED_SOD = 16'h0040;
  localparam logic [15:0] MASKED_RDY = 16'h0021;
  localparam logic [15:0] MASKED_SON = 16'h0023;
  localparam logic [15:0] MASKED_OPN = 16'h0027;
  localparam logic [15:0] MASKED_QS  = 16'h0007;
  localparam logic [15:0] MASKED_FQS = 16'h0008;
  localparam logic [15:0] MASKED_FLT = 16'h0028;
  localparam logic [6:0]  LOW_RDY_NOSUP = 7'h21;
  localparam logic [6:0]  LOW_RDY_SUP   = 7'h31;

  typedef enum logic [1:0] {SUPPLY_SHARED, SUPPLY_SEPARATE, SUPPLY_CONTACTOR} supply_mode_t;
  typedef enum logic [2:0] {
    ST_NOT_READY, ST_SOD, ST_READY, ST_SON, ST_OPEN, ST_QSTOP, ST_FREACT, ST_FAULT
  } drive_state_t;
endpackage

// >>> logic/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] pin_s
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta_reg[i] <= 1'b0;
        pin_s[i]    <= 1'b0;
      end else begin
        meta_reg[i] <= pin[i];
        pin_s[i]    <= meta_reg[i];
      end
    end
  end
endmodule

// >>> logic/mains_timer.sv
`timescale 1ns/1ps
module mains_timer #(
  parameter int TICK_CYCLES = 20000
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        run,
  input  wire logic [15:0] limit_ms,
  output logic             expired
);
  localparam int DW = $clog2(TICK_CYCLES + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(TICK_CYCLES - 1);

  logic [DW-1:0] div_reg;
  logic [15:0]   ms_reg;
  wire           tick = (div_reg == DIV_LAST);

  // millisecond enable pulse; restarts whenever the wait is abandoned
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_reg <= '0;
      ms_reg  <= '0;
      expired <= 1'b0;
    end else begin
      div_reg <= tick ? '0 : div_reg + 1'b1;
      if (tick && ms_reg != limit_ms) begin
        ms_reg <= ms_reg + 1'b1;
      end
      expired <= (ms_reg == limit_ms);
    end
  end
endmodule

// >>> testbench/plc_model.sv
`timescale 1ns/1ps
module plc_model (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  // each request stands until the edge that sees its ready; answers are taken at their own edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    wdata  <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// >>> testbench/tb_drive_state_status_word.sv
`timescale 1ns/1ps
module tb_drive_state_status_word;
  import drive_state_pkg::*;
  logic aclk, aresetn, awv, awr, wv, wr_y, bv, br, arv, arr, rv, rr;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdt, rdv;
  logic [1:0] bre, rre, rsp;
  logic sup, flt, mst, net, rch, lim, cc, mp, hlt, nsi;
  logic [15:0] dsw;
  int miscompares = 0;
  int comparisons = 0;
  drive_state_status_word #(.TICK_CYCLES(4)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_y), .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr), .supply_present(sup),
    .fault_in(flt), .motor_stopped(mst), .warning_in(1'b0), .net_control(net),
    .ref_reached(rch), .ref_limit(lim), .stop_key(1'b0), .dir_reverse(1'b0),
    .drive_state_word(dsw), .contactor_close(cc), .motor_power(mp),
    .halt_active(hlt), .no_supply_indication(nsi));
  plc_model plc_u (
    .aclk(aclk), .awaddr(awa), .awvalid(awv), .awready(awr), .wdata(wd), .wvalid(wv),
    .wready(wr_y), .bresp(bre), .bvalid(bv), .bready(br), .araddr(ara), .arvalid(arv),
    .arready(arr), .rdata(rdt), .rresp(rre), .rvalid(rv), .rready(rr));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic give_verdict();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic get(input logic [3:0] a);
    plc_u.rd({4'h0, a}, rdv, rsp);
  endtask
  task automatic put(input logic [3:0] a, input logic [31:0] d);
    plc_u.wr({4'h0, a}, d, rsp);
    repeat (3) @(posedge aclk);
  endtask
  // state is identified by masking, as a network controller would
  task automatic st(input logic [15:0] e);
    get(ADDR_STATUS);
    chk(rdv[15:0] & STATE_MASK, {16'h0, e});
    chk(dsw & STATE_MASK, e);
  endtask
  task automatic pins(input logic f, input logic m);
    flt <= f;
    mst <= m;
    repeat (6) @(posedge aclk);
  endtask
  initial begin
    aresetn = 1'b0;
    {sup, flt, mst, net, rch, lim} <= 6'b100000;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    st(MASKED_SOD);
    get(ADDR_CTRL);
    chk(rdv, {16'h0, CTRL_RESET});
    get(ADDR_CFG);
    chk(rdv, CFG_RESET);
    get(4'h7);
    chk(rsp, RESP_SLVERR);
    plc_u.wr(8'h00, 32'h0, rsp);
    chk(rsp, RESP_SLVERR);
    put(ADDR_CTRL, 32'h0006);
    st(MASKED_RDY);
    chk(rdv[6:0], LOW_RDY_SUP);
    put(ADDR_CTRL, 32'h000F);
    st(MASKED_OPN);
    {net, rch, lim} <= 3'b111;
    repeat (6) @(posedge aclk);
    get(ADDR_STATUS);
    chk(rdv[11:8], 4'hE);
    put(ADDR_CTRL, 32'h010F);
    chk(hlt, 1'b1);
    chk(mp, 1'b0);
    st(MASKED_OPN);
    put(ADDR_CTRL, 32'h0007);
    st(MASKED_SON);
    put(ADDR_CTRL, 32'h000F);
    put(ADDR_CTRL, 32'h000B);
    st(MASKED_QS);
    chk(mp, 1'b1);
    pins(1'b1, 1'b0);
    st(MASKED_FQS);
    pins(1'b0, 1'b0);
    put(ADDR_CTRL, 32'h0080);
    st(MASKED_SOD);
    pins(1'b1, 1'b0);
    st(MASKED_FLT);
    pins(1'b0, 1'b0);
    put(ADDR_CTRL, 32'h0080);
    st(MASKED_FLT);
    put(ADDR_CTRL, 32'h0000);
    put(ADDR_CTRL, 32'h0080);
    st(MASKED_SOD);
    put(ADDR_CFG, 32'h0000_0002);
    put(ADDR_CTRL, 32'h0006);
    chk(cc, 1'b0);
    put(ADDR_CTRL, 32'h0007);
    chk(cc, 1'b1);
    st(MASKED_SON);
    put(ADDR_CTRL, 32'h0000);
    st(MASKED_SOD);
    sup <= 1'b0;
    put(ADDR_CFG, 32'h0008_0001);
    put(ADDR_CTRL, 32'h0006);
    get(ADDR_STATUS);
    chk(rdv[6:0], LOW_RDY_NOSUP);
    chk(nsi, 1'b1);
    put(ADDR_CTRL, 32'h0007);
    st(MASKED_SON);
    repeat (40) @(posedge aclk);
    st(MASKED_FLT);
    get(ADDR_CAUSE);
    chk(rdv[0], 1'b1);
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge aclk);
    miscompares++;
    give_verdict();
  end
endmodule
